// ==== verilog/clock_switch_pkg.sv ====
// constants, carriers and state layout of the clock switch block
package clock_switch_pkg;
  // ==========================================================
  // register map (byte addresses on the plain register port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PLL = 4'h4;
  localparam logic [3:0] ADDR_TRIM = 4'h8;
  localparam logic [3:0] ADDR_KEY = 4'hc;
  // unlock keys, written in this order to the key register
  localparam logic [15:0] KEY_FIRST = 16'h0046;
  localparam logic [15:0] KEY_SECOND = 16'h0057;
  // ==========================================================
  // field positions of the control register
  localparam int CUR_LSB = 12;
  localparam int NEXT_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SECEN_BIT = 1;
  localparam int SWREQ_BIT = 0;
  // ==========================================================
  // reset values and arithmetic constants
  localparam logic [8:0] PLL_DIV_RESET = 9'h030;
  localparam logic [9:0] PLL_MUL_OFFSET = 10'h002;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [15:0] TRIM_STEP_MILLI = 16'h0177;
  // ==========================================================
  // timing counts
  localparam logic [3:0] SWITCH_EDGES = 4'ha;
  localparam logic [9:0] STARTUP_EDGES = 10'h3ff;
  localparam logic [3:0] FAIL_WINDOW = 4'h4;
  // ==========================================================
  // source codes and primary submodes
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY = 3'h2;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_LOW_RC = 3'h5;
  localparam logic [2:0] SRC_FAST_RC_16 = 3'h6;
  localparam logic [2:0] SRC_FAST_RC_N = 3'h7;
  localparam logic [1:0] PRI_EXT_CLOCK = 2'h0;
  localparam logic [1:0] PRI_CRYSTAL = 2'h1;
  localparam logic [1:0] PRI_HIGH_SPEED = 2'h2;
  // ==========================================================
  // carriers and state
  typedef struct packed {
    logic fastRc;
    logic primary;
    logic secondary;
    logic lowRc;
    logic pll;
  } osc_bus_t;
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_COUNT, SW_HAND} sw_state_t;
  typedef struct packed {
    sw_state_t sw;
    logic [2:0] cur;
    logic [2:0] nxt;
    logic swReq;
    logic clkFail;
    logic lock;
    logic secEn;
    logic [1:0] unlockStage;
    logic [8:0] pll_feedback_divisor;
    logic [9:0] pllMul;
    logic [5:0] trim;
    logic [15:0] trimOff;
    osc_bus_t s1;
    osc_bus_t s2;
    osc_bus_t s3;
    logic lockS1;
    logic lockS2;
    logic [3:0] edgeCnt;
    logic [9:0] startCnt;
    logic [3:0] lowCnt;
    osc_bus_t en;
    logic pllRefPri;
    logic trap;
    logic sysClk;
    logic [15:0] rdata;
  } state_t;
endpackage : clock_switch_pkg

// ==== verilog/clock_switch_and_failsafe.sv ====
// clock source switch sequencer, fail-safe monitor and tuning registers
// Functional notes
// - multiplier equals divisor field plus two
// - divisor field powers up giving multiplier 50
// - tuning registers cleared only by power-on
// - trim is signed, 0.375 percent per step
// - switching and monitor need config bit zero
// - disabled: current source follows initial config
// - disabled: switch request ignored, reads zero
// - same source requested: request cleared, aborted
// - valid switch clears lock and fail flags
// - start new oscillator, crystal waits startup
// - PLL target waits for PLL lock
// - count ten new clock edges before changeover
// - changeover clears request, copies next to current
// - old source stops, low RC/secondary excepted
// - processor keeps running during the switch
// - primary submode fixed by configuration only
// - monitor on keeps low RC running except Sleep
// - failure raises trap, falls back to fast RC
// - failed PLL source falls back to fast RC PLL
// - three-bit source codes as listed
// - fail flag reads one after detected failure
// - lock bit reads one only while PLL locked
// - control writes rejected without unlock
`timescale 1ns/1ps
module clock_switch_and_failsafe #(
  parameter logic [9:0] STARTUP_COUNT = clock_switch_pkg::STARTUP_EDGES,
  parameter logic [3:0] FAIL_COUNT = clock_switch_pkg::FAIL_WINDOW
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic porReset_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [15:0] rdata,
  input wire logic switchMonitorCfg,
  input wire logic [2:0] initialSourceCfg,
  input wire logic [1:0] primarySubmodeCfg,
  input wire logic watchdogEnable,
  input wire logic sleepMode,
  input wire clock_switch_pkg::osc_bus_t oscIn,
  input wire logic pllLockIn,
  output clock_switch_pkg::osc_bus_t oscEnable,
  output logic pllRefPrimary,
  output logic [9:0] pllMultiplier,
  output logic [5:0] fastRcTrim,
  output logic [15:0] trimOffset,
  output logic [2:0] sysClkSrc,
  output logic sysClkOut,
  output logic clockFailTrap
);
  // ==========================================================
  // helpers
  // source codes that run from the PLL
  function automatic logic usesPll(input logic [2:0] code);
    usesPll = (code == clock_switch_pkg::SRC_FAST_RC_PLL) ||
              (code == clock_switch_pkg::SRC_PRIMARY_PLL);
  endfunction : usesPll

  // level or edge of the oscillator behind a source code
  function automatic logic srcOf(input logic [2:0] code,
                                 input clock_switch_pkg::osc_bus_t b);
    case (code)
      clock_switch_pkg::SRC_FAST_RC_PLL,
      clock_switch_pkg::SRC_PRIMARY_PLL: srcOf = b.pll;
      clock_switch_pkg::SRC_PRIMARY: srcOf = b.primary;
      clock_switch_pkg::SRC_SECONDARY: srcOf = b.secondary;
      clock_switch_pkg::SRC_LOW_RC: srcOf = b.lowRc;
      default: srcOf = b.fastRc;
    endcase
  endfunction : srcOf

  // oscillators a source code keeps running
  function automatic clock_switch_pkg::osc_bus_t needOf(
      input logic [2:0] code);
    needOf = '0;
    case (code)
      clock_switch_pkg::SRC_FAST_RC_PLL: begin
        needOf.fastRc = 1'b1;
        needOf.pll = 1'b1;
      end
      clock_switch_pkg::SRC_PRIMARY: needOf.primary = 1'b1;
      clock_switch_pkg::SRC_PRIMARY_PLL: begin
        needOf.primary = 1'b1;
        needOf.pll = 1'b1;
      end
      clock_switch_pkg::SRC_SECONDARY: needOf.secondary = 1'b1;
      clock_switch_pkg::SRC_LOW_RC: needOf.lowRc = 1'b1;
      default: needOf.fastRc = 1'b1;
    endcase
  endfunction : needOf

  // ==========================================================
  // state
  clock_switch_pkg::state_t st_ff;
  clock_switch_pkg::state_t nxt_st;
  clock_switch_pkg::osc_bus_t edges;
  logic swEn;
  logic failEvt;
  logic ready;
  logic crystal;
  logic ctrlWrite;
  clock_switch_pkg::osc_bus_t nxtNeed;

  // rising edges use only the second and third sampling stages
  assign edges = st_ff.s2 & ~st_ff.s3;
  assign swEn = (switchMonitorCfg == 1'b0);
  // external clock needs no startup wait; the submode never changes here
  assign crystal = (primarySubmodeCfg == clock_switch_pkg::PRI_CRYSTAL) ||
                   (primarySubmodeCfg == clock_switch_pkg::PRI_HIGH_SPEED);
  assign ctrlWrite = wrEn && (addr == clock_switch_pkg::ADDR_CTRL) &&
                     (st_ff.unlockStage == 2'h2);
  // no active edge seen for a whole low RC window
  assign failEvt = swEn && !sleepMode && (st_ff.lowCnt >= FAIL_COUNT) &&
                   (st_ff.cur != clock_switch_pkg::SRC_LOW_RC);
  assign nxtNeed = needOf(st_ff.nxt);
  assign ready =
      (!nxtNeed.primary || !crystal ||
       (st_ff.startCnt == STARTUP_COUNT)) &&
      (!usesPll(st_ff.nxt) || (st_ff.lockS2 && st_ff.en.pll));

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.trap = 1'b0;
    nxt_st.rdata = 16'h0000;
    // two flip-flops in front of every outside clock and the lock pin
    nxt_st.s1 = oscIn;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.lockS1 = pllLockIn;
    nxt_st.lockS2 = st_ff.lockS1;
    nxt_st.pllMul = {1'b0, st_ff.pll_feedback_divisor} +
                    clock_switch_pkg::PLL_MUL_OFFSET;
    // signed step count scaled to thousandths of a percent
    nxt_st.trimOff = 16'({{10{st_ff.trim[5]}}, st_ff.trim} *
                     clock_switch_pkg::TRIM_STEP_MILLI);
    nxt_st.lock = st_ff.en.pll && st_ff.lockS2;

    // unlock: two keys in a row arm exactly one control write
    if (wrEn) begin
      if (addr == clock_switch_pkg::ADDR_KEY) begin
        if (wdata == clock_switch_pkg::KEY_FIRST) begin
          nxt_st.unlockStage = 2'h1;
        end else if (st_ff.unlockStage == 2'h1 &&
                     wdata == clock_switch_pkg::KEY_SECOND) begin
          nxt_st.unlockStage = 2'h2;
        end else begin
          nxt_st.unlockStage = 2'h0;
        end
      end else begin
        nxt_st.unlockStage = 2'h0;
      end
    end

    // register writes; the control word loses a write if not armed
    if (ctrlWrite) begin
      nxt_st.nxt = wdata[clock_switch_pkg::NEXT_LSB +: 3];
      nxt_st.secEn = wdata[clock_switch_pkg::SECEN_BIT];
      if (!wdata[clock_switch_pkg::FAIL_BIT]) begin
        nxt_st.clkFail = 1'b0;
      end
      if (swEn && wdata[clock_switch_pkg::SWREQ_BIT]) begin
        nxt_st.swReq = 1'b1;
      end
    end
    if (wrEn && addr == clock_switch_pkg::ADDR_PLL) begin
      nxt_st.pll_feedback_divisor = wdata[8:0];
    end
    if (wrEn && addr == clock_switch_pkg::ADDR_TRIM) begin
      nxt_st.trim = wdata[5:0];
    end

    // read data stand in the cycle after the strobe
    if (rdEn) begin
      case (addr)
        clock_switch_pkg::ADDR_CTRL: begin
          nxt_st.rdata[clock_switch_pkg::CUR_LSB +: 3] = st_ff.cur;
          nxt_st.rdata[clock_switch_pkg::NEXT_LSB +: 3] = st_ff.nxt;
          nxt_st.rdata[clock_switch_pkg::LOCK_BIT] = st_ff.lock;
          nxt_st.rdata[clock_switch_pkg::FAIL_BIT] = st_ff.clkFail;
          nxt_st.rdata[clock_switch_pkg::SECEN_BIT] = st_ff.secEn;
          nxt_st.rdata[clock_switch_pkg::SWREQ_BIT] = st_ff.swReq;
        end
        clock_switch_pkg::ADDR_PLL: nxt_st.rdata = {7'h00, st_ff.pll_feedback_divisor};
        clock_switch_pkg::ADDR_TRIM: nxt_st.rdata = {10'h000, st_ff.trim};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end

    // startup timer counts primary edges from the moment it is enabled
    if (!st_ff.en.primary) begin
      nxt_st.startCnt = 10'h000;
    end else if (edges.primary && st_ff.startCnt != STARTUP_COUNT) begin
      nxt_st.startCnt = st_ff.startCnt + 10'h001;
    end

    // switch sequencer; the processor is never stalled by it
    case (st_ff.sw)
      clock_switch_pkg::SW_IDLE: begin
        if (st_ff.swReq) begin
          if (st_ff.nxt == st_ff.cur) begin
            nxt_st.swReq = 1'b0;
          end else begin
            nxt_st.lock = 1'b0;
            nxt_st.clkFail = 1'b0;
            nxt_st.sw = clock_switch_pkg::SW_WAIT;
          end
        end
      end
      clock_switch_pkg::SW_WAIT: begin
        nxt_st.edgeCnt = 4'h0;
        if (ready) begin
          nxt_st.sw = clock_switch_pkg::SW_COUNT;
        end
      end
      clock_switch_pkg::SW_COUNT: begin
        if (st_ff.edgeCnt == clock_switch_pkg::SWITCH_EDGES) begin
          nxt_st.sw = clock_switch_pkg::SW_HAND;
        end else if (srcOf(st_ff.nxt, edges)) begin
          nxt_st.edgeCnt = st_ff.edgeCnt + 4'h1;
        end
      end
      clock_switch_pkg::SW_HAND: begin
        // equal levels: the output cannot emit a short pulse here
        if (srcOf(st_ff.cur, st_ff.s2) == srcOf(st_ff.nxt, st_ff.s2)) begin
          nxt_st.cur = st_ff.nxt;
          nxt_st.swReq = 1'b0;
          nxt_st.sw = clock_switch_pkg::SW_IDLE;
        end
      end
      default: nxt_st.sw = clock_switch_pkg::SW_IDLE;
    endcase

    // fail-safe window counted in low RC edges
    if (!swEn || sleepMode || srcOf(st_ff.cur, edges)) begin
      nxt_st.lowCnt = 4'h0;
    end else if (edges.lowRc && st_ff.lowCnt < FAIL_COUNT) begin
      nxt_st.lowCnt = st_ff.lowCnt + 4'h1;
    end
    // placed after the writes so a failure beats a clearing write
    if (failEvt) begin
      nxt_st.cur = usesPll(st_ff.cur) ? clock_switch_pkg::SRC_FAST_RC_PLL
                                      : clock_switch_pkg::SRC_FAST_RC;
      nxt_st.clkFail = 1'b1;
      nxt_st.trap = 1'b1;
      nxt_st.swReq = 1'b0;
      nxt_st.sw = clock_switch_pkg::SW_IDLE;
      nxt_st.lowCnt = 4'h0;
    end

    // switching disabled: configuration picks the source
    if (!swEn) begin
      nxt_st.cur = initialSourceCfg;
      nxt_st.swReq = 1'b0;
      nxt_st.sw = clock_switch_pkg::SW_IDLE;
    end

    // oscillator enables: current, pending target and the exceptions
    nxt_st.en = needOf(st_ff.cur);
    if (st_ff.sw != clock_switch_pkg::SW_IDLE) begin
      nxt_st.en = nxt_st.en | needOf(st_ff.nxt);
    end
    if (st_ff.secEn) begin
      nxt_st.en.secondary = 1'b1;
    end
    if ((swEn || watchdogEnable) && !sleepMode) begin
      nxt_st.en.lowRc = 1'b1;
    end
    nxt_st.pllRefPri =
        (st_ff.sw != clock_switch_pkg::SW_IDLE && usesPll(st_ff.nxt)) ?
        (st_ff.nxt == clock_switch_pkg::SRC_PRIMARY_PLL) :
        (st_ff.cur == clock_switch_pkg::SRC_PRIMARY_PLL);
    nxt_st.sysClk = srcOf(st_ff.cur, st_ff.s2);
  end

  // ==========================================================
  // registers; a warm reset leaves the tuning registers alone
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !porReset_n) begin
      st_ff <= '0;
      st_ff.cur <= initialSourceCfg;
      st_ff.pll_feedback_divisor <= st_ff.pll_feedback_divisor;
      st_ff.pllMul <= st_ff.pllMul;
      st_ff.trim <= st_ff.trim;
      st_ff.trimOff <= st_ff.trimOff;
      if (!porReset_n) begin
        st_ff.pll_feedback_divisor <= clock_switch_pkg::PLL_DIV_RESET;
        st_ff.pllMul <= {1'b0, clock_switch_pkg::PLL_DIV_RESET} +
                        clock_switch_pkg::PLL_MUL_OFFSET;
        st_ff.trim <= clock_switch_pkg::TRIM_RESET;
        st_ff.trimOff <= 16'h0000;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign oscEnable = st_ff.en;
  assign pllRefPrimary = st_ff.pllRefPri;
  assign pllMultiplier = st_ff.pllMul;
  assign fastRcTrim = st_ff.trim;
  assign trimOffset = st_ff.trimOff;
  assign sysClkSrc = st_ff.cur;
  assign sysClkOut = st_ff.sysClk;
  assign clockFailTrap = st_ff.trap;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n || !porReset_n);

  property p_mul;
    ##1 pllMultiplier == {1'b0, $past(st_ff.pll_feedback_divisor)} + 10'h002;
  endproperty
  a_mul: assert property (p_mul)
    else $error("multiplier not divisor plus two");

  property p_req_off;
    !swEn |=> !st_ff.swReq;
  endproperty
  a_req_off: assert property (p_req_off)
    else $error("switch request set while disabled");

  property p_follow_cfg;
    !swEn |=> sysClkSrc == $past(initialSourceCfg);
  endproperty
  a_follow_cfg: assert property (p_follow_cfg)
    else $error("current source not following config");

  property p_redundant;
    swEn && st_ff.sw == clock_switch_pkg::SW_IDLE && st_ff.swReq &&
    st_ff.nxt == st_ff.cur && !failEvt |=> !st_ff.swReq && $stable(sysClkSrc);
  endproperty
  a_redundant: assert property (p_redundant)
    else $error("redundant switch not aborted");

  property p_start_clear;
    swEn && st_ff.sw == clock_switch_pkg::SW_IDLE && st_ff.swReq &&
    st_ff.nxt != st_ff.cur && !failEvt |=> !st_ff.clkFail && !st_ff.lock;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("flags not cleared at switch start");

  property p_hand_count;
    st_ff.sw == clock_switch_pkg::SW_HAND |->
      st_ff.edgeCnt == clock_switch_pkg::SWITCH_EDGES;
  endproperty
  a_hand_count: assert property (p_hand_count)
    else $error("changeover before ten edges");

  property p_commit;
    st_ff.sw == clock_switch_pkg::SW_HAND && swEn && !failEvt ##1
      $changed(sysClkSrc) |-> !st_ff.swReq && sysClkSrc == $past(st_ff.nxt);
  endproperty
  a_commit: assert property (p_commit)
    else $error("changeover did not commit next source");

  property p_fail;
    failEvt && swEn |=> clockFailTrap && st_ff.clkFail &&
      (sysClkSrc == clock_switch_pkg::SRC_FAST_RC ||
       sysClkSrc == clock_switch_pkg::SRC_FAST_RC_PLL) ##1 !clockFailTrap;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failure not trapped or not fallen back");

  property p_low_rc;
    swEn && !sleepMode |=> oscEnable.lowRc;
  endproperty
  a_low_rc: assert property (p_low_rc)
    else $error("low RC stopped while monitor on");

  property p_lock_bit;
    st_ff.lock |-> $past(st_ff.lockS2) && $past(st_ff.en.pll);
  endproperty
  a_lock_bit: assert property (p_lock_bit)
    else $error("lock bit set without PLL lock");
endmodule : clock_switch_and_failsafe

// ==== test/testbench.sv ====
// self-checking bench for the clock switch and fail-safe block
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic porReset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [15:0] rdata;
  logic switchMonitorCfg = 1'b0;
  logic [2:0] initialSourceCfg = clock_switch_pkg::SRC_FAST_RC;
  logic [1:0] primarySubmodeCfg = clock_switch_pkg::PRI_CRYSTAL;
  logic watchdogEnable = 1'b0;
  logic sleepMode = 1'b0;
  clock_switch_pkg::osc_bus_t oscIn = '0;
  logic pllLockIn = 1'b1;
  clock_switch_pkg::osc_bus_t oscEnable;
  logic pllRefPrimary;
  logic [9:0] pllMultiplier;
  logic [5:0] fastRcTrim;
  logic [15:0] trimOffset;
  logic [2:0] sysClkSrc;
  logic sysClkOut;
  logic clockFailTrap;
  logic kill = 1'b0;
  logic [3:0] phase = 4'h0;
  logic [15:0] d;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  int t0;

  // short startup count keeps the crystal wait inside the run budget
  clock_switch_and_failsafe #(
    .STARTUP_COUNT(10'h004),
    .FAIL_COUNT(4'h4)
  ) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .porReset_n(porReset_n),
    .addr(addr), .wdata(wdata), .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata),
    .switchMonitorCfg(switchMonitorCfg),
    .initialSourceCfg(initialSourceCfg),
    .primarySubmodeCfg(primarySubmodeCfg),
    .watchdogEnable(watchdogEnable), .sleepMode(sleepMode),
    .oscIn(oscIn), .pllLockIn(pllLockIn), .oscEnable(oscEnable),
    .pllRefPrimary(pllRefPrimary), .pllMultiplier(pllMultiplier),
    .fastRcTrim(fastRcTrim), .trimOffset(trimOffset),
    .sysClkSrc(sysClkSrc), .sysClkOut(sysClkOut),
    .clockFailTrap(clockFailTrap)
  );

  // ==========================================================
  // clock, oscillator stand-ins and hang guard
  always #5 clk_sys = ~clk_sys;

  // an oscillator runs only while enabled; kill models a dead crystal
  // a PLL fed from fast RC keeps running when the crystal dies
  always @(posedge clk_sys) begin
    phase <= phase + 4'h1;
    oscIn.fastRc <= oscEnable.fastRc & phase[1];
    oscIn.pll <= oscEnable.pll & phase[1] & ~(kill & pllRefPrimary);
    oscIn.primary <= oscEnable.primary & phase[2] & ~kill;
    oscIn.secondary <= oscEnable.secondary & phase[2];
    oscIn.lowRc <= oscEnable.lowRc & phase[3];
  end

  // whole run is under a thousand cycles; this ceiling only trips a hang
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  // ==========================================================
  // shared tasks
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wrEn <= 1'b1;
    @(posedge clk_sys);
    wrEn <= 1'b0;
  endtask : wr

  // derived outputs are registered one edge after the write lands
  task settle();
    @(posedge clk_sys);
    #1;
  endtask : settle

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // every control write needs its own fresh key pair
  task ctl(input logic [15:0] v);
    wr(clock_switch_pkg::ADDR_KEY, clock_switch_pkg::KEY_FIRST);
    wr(clock_switch_pkg::ADDR_KEY, clock_switch_pkg::KEY_SECOND);
    wr(clock_switch_pkg::ADDR_CTRL, v);
  endtask : ctl

  task rst(input logic por);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    porReset_n <= ~por;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    porReset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : rst

  task wait_src(input logic [2:0] s);
    n = 0;
    while (sysClkSrc !== s && n < 3000) begin
      @(posedge clk_sys);
      #1 n = n + 1;
    end
  endtask : wait_src

  task wait_trap();
    n = 0;
    while (clockFailTrap !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1 n = n + 1;
    end
  endtask : wait_trap

  // ==========================================================
  // scenarios
  task t_tuning();
    rst(1'b1);
    rd(clock_switch_pkg::ADDR_PLL, d);
    chk(d, 16'h0030);
    chk({6'h00, pllMultiplier}, 16'h0032);
    wr(clock_switch_pkg::ADDR_PLL, 16'h0000);
    settle();
    chk({6'h00, pllMultiplier}, 16'h0002);
    wr(clock_switch_pkg::ADDR_PLL, 16'hffff);
    rd(clock_switch_pkg::ADDR_PLL, d);
    chk(d, 16'h01ff);
    chk({6'h00, pllMultiplier}, 16'h0201);
    wr(clock_switch_pkg::ADDR_TRIM, 16'h0020);
    settle();
    chk(trimOffset, 16'hd120);
    wr(clock_switch_pkg::ADDR_TRIM, 16'h001f);
    settle();
    chk(trimOffset, 16'h2d69);
    rst(1'b0);
    rd(clock_switch_pkg::ADDR_PLL, d);
    chk(d, 16'h01ff);
    rd(clock_switch_pkg::ADDR_TRIM, d);
    chk(d, 16'h001f);
    rst(1'b1);
    chk({6'h00, pllMultiplier}, 16'h0032);
    chk({10'h000, fastRcTrim}, 16'h0000);
  endtask : t_tuning

  task t_disabled();
    switchMonitorCfg <= 1'b1;
    initialSourceCfg <= clock_switch_pkg::SRC_SECONDARY;
    rst(1'b0);
    ctl(16'h0201);
    repeat (40) @(posedge clk_sys);
    rd(clock_switch_pkg::ADDR_CTRL, d);
    chk({15'h0000, d[0]}, 16'h0000);
    chk({13'h0000, d[14:12]}, 16'h0004);
    chk({13'h0000, sysClkSrc}, 16'h0004);
    // the output follows the secondary stand-in: half of 16 cycles high
    n = 0;
    repeat (16) begin
      @(posedge clk_sys);
      #1 n = n + sysClkOut;
    end
    chk(16'(n), 16'h0008);
  endtask : t_disabled

  task t_unlock_same();
    switchMonitorCfg <= 1'b0;
    initialSourceCfg <= clock_switch_pkg::SRC_FAST_RC;
    rst(1'b0);
    wr(clock_switch_pkg::ADDR_CTRL, 16'h0200);
    rd(clock_switch_pkg::ADDR_CTRL, d);
    chk({13'h0000, d[10:8]}, 16'h0000);
    ctl(16'h0001);
    repeat (6) @(posedge clk_sys);
    rd(clock_switch_pkg::ADDR_CTRL, d);
    chk({15'h0000, d[0]}, 16'h0000);
    chk({13'h0000, sysClkSrc}, 16'h0000);
  endtask : t_unlock_same

  task t_switch_primary();
    t0 = cyc;
    ctl(16'h0201);
    wait_src(clock_switch_pkg::SRC_PRIMARY);
    chk({13'h0000, sysClkSrc}, 16'h0002);
    // ten primary edges at eight cycles each come first
    chk({15'h0000, (cyc - t0) >= 80}, 16'h0001);
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, oscEnable.fastRc}, 16'h0000);
    chk({15'h0000, oscEnable.lowRc}, 16'h0001);
    rd(clock_switch_pkg::ADDR_CTRL, d);
    chk({12'h000, d[14:12], d[0]}, 16'h0004);
  endtask : t_switch_primary

  task t_fail_then_pll();
    kill <= 1'b1;
    wait_trap();
    chk({15'h0000, clockFailTrap}, 16'h0001);
    @(posedge clk_sys);
    #1 chk({15'h0000, clockFailTrap}, 16'h0000);
    chk({13'h0000, sysClkSrc}, 16'h0000);
    kill <= 1'b0;
    rd(clock_switch_pkg::ADDR_CTRL, d);
    chk({15'h0000, d[3]}, 16'h0001);
    // lock held low: the switch must stall in its wait
    pllLockIn <= 1'b0;
    // the PLL target is reached here from plain fast RC; the sequencer would also accept a PLL mode
    ctl(16'h0309);
    repeat (4) @(posedge clk_sys);
    rd(clock_switch_pkg::ADDR_CTRL, d);
    chk({14'h0000, d[5], d[3]}, 16'h0000);
    repeat (200) @(posedge clk_sys);
    chk({13'h0000, sysClkSrc}, 16'h0000);
    pllLockIn <= 1'b1;
    wait_src(clock_switch_pkg::SRC_PRIMARY_PLL);
    chk({13'h0000, sysClkSrc}, 16'h0003);
    rd(clock_switch_pkg::ADDR_CTRL, d);
    chk({15'h0000, d[5]}, 16'h0001);
    chk({15'h0000, pllRefPrimary}, 16'h0001);
    kill <= 1'b1;
    wait_trap();
    @(posedge clk_sys);
    #1 chk({13'h0000, sysClkSrc}, 16'h0001);
    chk({15'h0000, pllRefPrimary}, 16'h0000);
    kill <= 1'b0;
  endtask : t_fail_then_pll

  // ==========================================================
  // verdict and main sequence
  task close_out();
    $display("miscompares %0d, n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    t_tuning();
    t_disabled();
    t_unlock_same();
    t_switch_primary();
    t_fail_then_pll();
    close_out();
  end
endmodule : testbench
